/* File: hw/rcr_pkg.sv */
// Package for the regulator control register bank.
// Assumes a byte-wide register port driven by a serial-bus front end elsewhere.
package rcr_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] CONV_VOLT_OFS = 8'h07; // Converter voltage control
	localparam logic [7:0] REG_VOLT_OFS  = 8'h08; // Linear regulator control
	localparam logic [7:0] MODE_STAT_OFS = 8'h09; // Converter mode and status
	localparam logic [7:0] HOLD_MISC_OFS = 8'h0a; // Supply hold and misc control
	// ==========================================
	// Field positions
	localparam int HOLD_SEL_BIT   = 7; // Hold select in both voltage registers
	localparam int DISCH_BIT      = 6; // Discharge enable in both voltage registers
	localparam int FPWM_BIT       = 7; // Forced fixed frequency
	localparam int CONV_NG_BIT    = 6; // Converter not good
	localparam int REG_NG_BIT     = 5; // Regulator not good
	localparam int KEEP_ON_BIT    = 5; // Supply keep-on
	localparam int BTN_STATE_BIT  = 4; // Debounced button
	localparam int AMP_SRC_BIT    = 2; // Amplifier source select
	localparam int AMP_EN_BIT     = 1; // Amplifier enable
	localparam int RST_DELAY_BIT  = 0; // Reset delay select
	// ==========================================
	// Reset values
	localparam logic [7:0] CONV_VOLT_RST = 8'h29;
	localparam logic [7:0] REG_VOLT_RST  = 8'h65;
	localparam logic [7:0] MODE_RST      = 8'h00;
	localparam logic [7:0] HOLD_MISC_RST = 8'h05;
	// Writable bit masks
	localparam logic [7:0] MODE_WMASK    = 8'h80;
	localparam logic [7:0] HOLD_WMASK    = 8'h27;
	// ==========================================
	// Voltage map and reset delays
	localparam int unsigned LOW_BASE_MV  = 800;
	localparam int unsigned LOW_STEP_MV  = 25;
	localparam int unsigned HIGH_BASE_MV = 1600;
	localparam int unsigned HIGH_STEP_MV = 50;
	localparam int unsigned TOP_BASE_MV  = 3000;
	localparam int unsigned TOP_STEP_MV  = 100;
	localparam int unsigned SHORT_DLY_MS = 11;
	localparam int unsigned LONG_DLY_MS  = 90;
	// Register bus request
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} rcr_req_t;
	// Power control outputs
	typedef struct packed {
		logic conv_en;
		logic conv_disch;
		logic reg_en;
		logic reg_disch;
		logic force_pwm;
		logic amp_en;
		logic amp_src;
		logic long_delay;
	} rcr_pwr_t;
endpackage : rcr_pkg

/* File: hw/rcr_top.sv */
// Register bank of the regulator control block.
// Assumes a bus front end presents byte writes and reads as one-cycle strobes.
// How it works
// - Converter discharges while disabled if enabled
// - Six-bit code maps to millivolts piecewise
// - Downward voltage steps never raise faults
// - Divider variants store code, keep voltage
// - Regulator hold bit overrides hold pin
// - Regulator discharges while disabled if enabled
// - Regulator code shares mapping; divider ignores
// - Forced bit selects fixed-frequency mode
// - Converter not-good reads live status
// - Regulator not-good reads live status
// - Keep-on ORed with button enables both
// - Button state shows debounced press
// - Source select picks battery or temperature
// - Amplifier on when enabled or input good
// - Delay bit selects 11 or 90 ms
// - Reset loads documented control defaults
// - Converter hold bit overrides hold pin
`timescale 1ns/1ps
`default_nettype none
module rcr_top import rcr_pkg::*; #(
	parameter bit CONV_DIVIDER = 1'b0, // Converter voltage set by divider
	parameter bit REG_DIVIDER  = 1'b0  // Regulator voltage set by divider
) (
	input  wire logic       sys_clk_in,       // 250 MHz clock
	input  wire logic       rst_in,           // Synchronous reset, high
	input  wire rcr_req_t   req_in,           // Register request
	input  wire logic       req_valid_in,     // Request strobe
	input  wire logic       conv_hold_pin_in, // Converter hold pin
	input  wire logic       reg_hold_pin_in,  // Regulator hold pin
	input  wire logic       button_input_in,  // Button level, high released
	input  wire logic       button_state_in,  // Debounced press
	input  wire logic       conv_good_in,     // Converter in range
	input  wire logic       reg_good_in,      // Regulator in range
	input  wire logic       charger_input_good_in, // Charger input good
	output logic [7:0]      rdata_out,        // Read data
	output logic            rvalid_out,       // Read data valid
	output rcr_pwr_t        pwr_out,          // Power controls
	output logic [11:0]     conv_mv_out,      // Converter target mV
	output logic [11:0]     reg_mv_out        // Regulator target mV
);
	// ==========================================
	// Voltage map
	// Three straight segments: fine steps low, coarser steps mid-range,
	// and the four top codes in large steps. The result is the target the
	// analog loop is asked for, in millivolts, so it fits in twelve bits.
	// Shared by both outputs so that the two code-to-millivolt maps can never drift apart.
	// The same function feeds the map checks further down.
	function automatic logic [11:0] code_mv(input logic [5:0] c);
		logic [11:0] v;
		v = 12'h000;
		if (c < 6'd32) begin
			v = 12'(LOW_BASE_MV + LOW_STEP_MV * c);
		end else if (c < 6'd60) begin
			v = 12'(HIGH_BASE_MV + HIGH_STEP_MV * (c - 6'd32));
		end else begin
			v = 12'(TOP_BASE_MV + TOP_STEP_MV * (c - 6'd60));
		end
		return v;
	endfunction : code_mv

	// ==========================================
	// Register state
	// Writable bits live in flip-flops; read-only bits are never stored,
	// they are composed into the read data from live inputs instead.
	// Every output is registered, so the power controls and the targets
	// both lag a register write by one edge; the bus sees no difference.
	logic [7:0]  conv_q, conv_d;   // Converter voltage control
	logic [7:0]  regv_q, regv_d;   // Regulator control
	logic [7:0]  mode_q, mode_d;   // Forced-mode bit
	logic [7:0]  misc_q, misc_d;   // Hold/misc writable bits
	logic [7:0]  rd_q, rd_d;       // Read data
	logic        rv_q, rv_d;       // Read valid
	rcr_pwr_t    pwr_q, pwr_d;     // Power outputs
	logic [11:0] cmv_q, cmv_d;     // Converter target
	logic [11:0] rmv_q, rmv_d;     // Regulator target
	logic [7:0]  live;             // Readback of selected register
	logic        wr_en;            // Write strobe

	// Next state computation
	// Writes, readback and the power decisions all sit in one process so
	// that each register has exactly one next-value expression.
	// Readback decodes the address even without a strobe; the result is
	// only captured when a read is taken, so idle decoding costs nothing.
	always_comb begin
		wr_en  = req_valid_in && req_in.wr;
		conv_d = conv_q;
		regv_d = regv_q;
		mode_d = mode_q;
		misc_d = misc_q;
		// Only writable bits move; status bits stay live
		if (wr_en) begin
			unique case (req_in.addr)
				CONV_VOLT_OFS: conv_d = req_in.data; // Stored even with divider
				REG_VOLT_OFS:  regv_d = req_in.data;
				MODE_STAT_OFS: mode_d = req_in.data & MODE_WMASK;
				HOLD_MISC_OFS: misc_d = req_in.data & HOLD_WMASK;
				default: ;
			endcase
		end
		// Readback composes live status bits
		unique case (req_in.addr)
			CONV_VOLT_OFS: live = conv_q;
			REG_VOLT_OFS:  live = regv_q;
			MODE_STAT_OFS: begin
				live = mode_q;
				live[CONV_NG_BIT] = ~conv_good_in || ~pwr_q.conv_en;
				live[REG_NG_BIT]  = ~reg_good_in || ~pwr_q.reg_en;
			end
			HOLD_MISC_OFS: begin
				live = misc_q;
				live[BTN_STATE_BIT] = button_state_in;
			end
			default: live = 8'h00; // Unmapped reads zero
		endcase
		rd_d = (req_valid_in && !req_in.wr) ? live : rd_q;
		rv_d = req_valid_in && !req_in.wr;
		// Enables: keep-on ORed with pressed button, hold pins
		pwr_d.conv_en = misc_q[KEEP_ON_BIT] || !button_input_in || conv_hold_pin_in
			|| conv_q[HOLD_SEL_BIT];
		pwr_d.reg_en  = misc_q[KEEP_ON_BIT] || !button_input_in || reg_hold_pin_in
			|| regv_q[HOLD_SEL_BIT];
		pwr_d.conv_disch = conv_q[DISCH_BIT] && !pwr_d.conv_en;
		pwr_d.reg_disch  = regv_q[DISCH_BIT] && !pwr_d.reg_en;
		pwr_d.force_pwm  = mode_q[FPWM_BIT];
		pwr_d.amp_src    = misc_q[AMP_SRC_BIT];
		pwr_d.amp_en     = misc_q[AMP_EN_BIT] || charger_input_good_in;
		pwr_d.long_delay = misc_q[RST_DELAY_BIT];
		// Targets follow code unless divider fixes them
		cmv_d = CONV_DIVIDER ? cmv_q : code_mv(conv_q[5:0]);
		rmv_d = REG_DIVIDER ? rmv_q : code_mv(regv_q[5:0]);
		// Downward steps apply directly, no fault path
	end

	// Registering
	// Synchronous reset loads the control defaults; the targets restart
	// at zero and follow the codes one cycle after release.
	// With a divider fitted the target stays at zero, since the code has
	// no say over the output voltage on such variants.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			conv_q <= CONV_VOLT_RST;
			regv_q <= REG_VOLT_RST;
			mode_q <= MODE_RST;
			misc_q <= HOLD_MISC_RST;
			rd_q   <= 8'h00;
			rv_q   <= 1'b0;
			pwr_q  <= '0;
			cmv_q  <= 12'h000;
			rmv_q  <= 12'h000;
		end else begin
			conv_q <= conv_d;
			regv_q <= regv_d;
			mode_q <= mode_d;
			misc_q <= misc_d;
			rd_q   <= rd_d;
			rv_q   <= rv_d;
			pwr_q  <= pwr_d;
			cmv_q  <= cmv_d;
			rmv_q  <= rmv_d;
		end
	end

	// ==========================================
	// Outputs
	// Every output is a plain copy of a flip-flop, so no glitch reaches
	// the analog side even while the bus decodes a new address.
	assign rdata_out   = rd_q;
	assign rvalid_out  = rv_q;
	assign pwr_out     = pwr_q;
	assign conv_mv_out = cmv_q;
	assign reg_mv_out  = rmv_q;

	// ==========================================
	// Checks
	// All checks but reset_load_a skip reset cycles. Outputs lag the registers by one edge,
	// so most checks look one cycle after the condition that causes them.

	// A discharging converter must never be switched on at the same time
	conv_disch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		pwr_out.conv_disch |-> !pwr_out.conv_en) else $error("discharge while on");

	// Same hazard for the linear regulator
	reg_disch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		pwr_out.reg_disch |-> !pwr_out.reg_en) else $error("reg discharge while on");

	// Discharge bit set: discharge exactly while the converter is off
	conv_disch_on_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		conv_q[DISCH_BIT] |=> pwr_out.conv_disch == !pwr_out.conv_en) else $error("no discharge");

	// Discharge bit clear: the converter output is left alone
	conv_disch_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!conv_q[DISCH_BIT] |=> !pwr_out.conv_disch) else $error("unwanted discharge");

	// Regulator discharge follows its own bit while off
	reg_disch_on_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		regv_q[DISCH_BIT] |=> pwr_out.reg_disch == !pwr_out.reg_en) else $error("no reg discharge");

	// Regulator discharge bit clear: never discharge
	reg_disch_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!regv_q[DISCH_BIT] |=> !pwr_out.reg_disch) else $error("unwanted reg discharge");

	// Keep-on alone holds both supplies up
	keep_on_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		misc_q[KEEP_ON_BIT] |=> pwr_out.conv_en && pwr_out.reg_en) else $error("keep-on");

	// A pressed button holds both supplies up as well
	button_on_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!button_input_in |=> pwr_out.conv_en && pwr_out.reg_en) else $error("button on");

	// Nothing holding the converter up: it must switch off
	conv_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!misc_q[KEEP_ON_BIT] && button_input_in && !conv_hold_pin_in && !conv_q[HOLD_SEL_BIT]
		|=> !pwr_out.conv_en) else $error("converter not off");

	// Hold select overrides a low hold pin
	conv_hold_sel_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		conv_q[HOLD_SEL_BIT] |=> pwr_out.conv_en) else $error("converter hold select");

	// Nothing holding the regulator up: it must switch off
	reg_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!misc_q[KEEP_ON_BIT] && button_input_in && !reg_hold_pin_in && !regv_q[HOLD_SEL_BIT]
		|=> !pwr_out.reg_en) else $error("regulator not off");

	// Regulator hold select overrides its pin
	reg_hold_sel_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		regv_q[HOLD_SEL_BIT] |=> pwr_out.reg_en) else $error("regulator hold select");

	// Charger input good switches the amplifier on by itself
	amp_auto_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		charger_input_good_in |=> pwr_out.amp_en) else $error("amp auto enable");

	// Enable bit switches the amplifier on
	amp_manual_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		misc_q[AMP_EN_BIT] |=> pwr_out.amp_en) else $error("amp manual enable");

	// Neither source of enable: the amplifier stays off
	amp_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!misc_q[AMP_EN_BIT] && !charger_input_good_in |=> !pwr_out.amp_en) else $error("amp on");

	// Source select is passed through one cycle later
	amp_src_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		1'b1 |=> pwr_out.amp_src == $past(misc_q[AMP_SRC_BIT])) else $error("amp source");

	// Reset delay select is passed through one cycle later
	delay_sel_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		1'b1 |=> pwr_out.long_delay == $past(misc_q[RST_DELAY_BIT])) else $error("delay select");

	// Forced mode output follows its bit
	fpwm_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		pwr_out.force_pwm == $past(mode_q[FPWM_BIT])) else $error("forced mode");

	// Reset always lands the mode and hold/misc defaults
	reset_load_a: assert property (@(posedge sys_clk_in)
		rst_in |=> misc_q == HOLD_MISC_RST && mode_q == MODE_RST) else $error("defaults");

	// Read-only places of the hold register are never stored
	ro_ignore_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		1'b1 |=> (misc_q & ~HOLD_WMASK) == 8'h00) else $error("ro bit stored");

	// Read-only places of the mode register are never stored
	mode_ro_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		1'b1 |=> (mode_q & ~MODE_WMASK) == 8'h00) else $error("ro mode bit stored");

	// Converter not-good reads the live state at the read
	conv_ng_rd_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		req_valid_in && !req_in.wr && req_in.addr == MODE_STAT_OFS |=> rdata_out[CONV_NG_BIT]
		== (!$past(conv_good_in) || !$past(pwr_q.conv_en))) else $error("converter status");

	// Regulator not-good reads the live state at the read
	reg_ng_rd_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		req_valid_in && !req_in.wr && req_in.addr == MODE_STAT_OFS |=> rdata_out[REG_NG_BIT]
		== (!$past(reg_good_in) || !$past(pwr_q.reg_en))) else $error("regulator status");

	// Button state reads the debounced input at the read
	btn_rd_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		req_valid_in && !req_in.wr && req_in.addr == HOLD_MISC_OFS
		|=> rdata_out[BTN_STATE_BIT] == $past(button_state_in)) else $error("button state");

	// Settled converter code shows as its mapped target
	code_map_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!CONV_DIVIDER && $stable(conv_q) ##1 $stable(conv_q)
		|-> conv_mv_out == code_mv(conv_q[5:0])) else $error("voltage map");

	// Settled regulator code uses the same map
	reg_map_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!REG_DIVIDER && $stable(regv_q) ##1 $stable(regv_q)
		|-> reg_mv_out == code_mv(regv_q[5:0])) else $error("regulator map");

	// A lower code of any size is taken at once, with no fault path
	step_down_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!CONV_DIVIDER && conv_q[5:0] < $past(conv_q[5:0])
		|=> conv_mv_out == code_mv($past(conv_q[5:0]))) else $error("downward step");

	// Divider variant: the converter target never moves
	conv_fixed_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		CONV_DIVIDER |=> $stable(conv_mv_out)) else $error("divider target moved");

	// Divider variant: the regulator target never moves
	reg_fixed_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		REG_DIVIDER |=> $stable(reg_mv_out)) else $error("divider reg target moved");
endmodule : rcr_top
`default_nettype wire

/* File: tb/rcr_host.sv */
// Host model that issues register writes and reads to the bank.
// Assumes one-cycle read answers and a bank clock shared with the bench.
`timescale 1ns/1ps
`default_nettype none
module rcr_host import rcr_pkg::*; (
	input  wire logic       clk_in,    // Bank clock
	input  wire logic       rvalid_in, // Read answer strobe
	input  wire logic [7:0] rdata_in,  // Read answer data
	output rcr_req_t        req_out,   // Request fields
	output logic            vld_out    // Request strobe
);
	// ==========================================
	// Request tasks
	initial begin
		req_out = '0;
		vld_out = 1'b0;
	end
	// Caller raises voltage codes one step at a time, well under 8 percent
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{1'b1, a, d};
		vld_out <= 1'b1;
		@(posedge clk_in);
		vld_out <= 1'b0;
		req_out <= '{1'b0, ~a, ~d}; // Scrambled so stale fields never pass as good
	endtask : wr
	// Bounded wait for the answer; ok stays low on a hang
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk_in);
		req_out <= '{1'b0, a, 8'h00};
		vld_out <= 1'b1;
		@(posedge clk_in);
		vld_out <= 1'b0;
		req_out <= '{1'b1, ~a, 8'hff};
		for (int i = 0; i < 8 && !ok; i++) begin
			#1;
			if (rvalid_in === 1'b1) begin
				d = rdata_in;
				ok = 1'b1;
			end else
				@(posedge clk_in);
		end
	endtask : rd
endmodule : rcr_host
`default_nettype wire

/* File: tb/rcr_top_tb.sv */
// Self-checking bench for the register bank, compared with a queue-free model.
// Assumes the host model in rcr_host and the bank's package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module rcr_top_tb import rcr_pkg::*;;
	logic        clk, rst, vld, rv, ok; // Clock, reset, strobes
	logic [6:0]  pin;                   // chold rhold btn bst cgood rgood chg
	rcr_req_t    req;                   // Request from host
	rcr_pwr_t    pwr, ep;               // Actual and expected controls
	logic [11:0] cmv, rmv;              // Target mV
	logic [11:0] cmv2, rmv2;            // Targets of the divider variant
	logic [7:0]  rdat, rd_d, m [4];     // Read data and model registers
	logic [31:0] lf = 32'h75b0;         // Random source
	int          n_fail, checked;
	rcr_top rcr_top_i (.sys_clk_in(clk), .rst_in(rst), .req_in(req), .req_valid_in(vld),
		.conv_hold_pin_in(pin[0]), .reg_hold_pin_in(pin[1]), .button_input_in(pin[2]),
		.button_state_in(pin[3]), .conv_good_in(pin[4]), .reg_good_in(pin[5]),
		.charger_input_good_in(pin[6]), .rdata_out(rdat), .rvalid_out(rv),
		.pwr_out(pwr), .conv_mv_out(cmv), .reg_mv_out(rmv));
	rcr_top #(.CONV_DIVIDER(1'b1), .REG_DIVIDER(1'b1)) rcr_top_div_i (.sys_clk_in(clk),
		.rst_in(rst), .req_in(req), .req_valid_in(vld), .conv_hold_pin_in(pin[0]),
		.reg_hold_pin_in(pin[1]), .button_input_in(pin[2]), .button_state_in(pin[3]),
		.conv_good_in(pin[4]), .reg_good_in(pin[5]), .charger_input_good_in(pin[6]),
		.rdata_out(), .rvalid_out(), .pwr_out(), .conv_mv_out(cmv2), .reg_mv_out(rmv2));
	rcr_host rcr_host_i (.clk_in(clk), .rvalid_in(rv), .rdata_in(rdat), .req_out(req),
		.vld_out(vld));
	// ==========================================
	// Model helpers
	function automatic logic [11:0] mv(input logic [5:0] c);
		if (c < 32) return 12'(800 + 25 * c);
		if (c < 60) return 12'(1600 + 50 * (c - 32));
		return 12'(3000 + 100 * (c - 60));
	endfunction : mv
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Reset loads documented defaults into both bank and model
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		m = '{8'h29, 8'h65, 8'h00, 8'h05};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	// Settle, then compare outputs and every register plus one unmapped place
	task automatic check_all();
		logic on_c, on_r;
		logic [7:0] ex [5];
		repeat (3) @(posedge clk);
		#1;
		on_c = m[3][5] | ~pin[2] | pin[0] | m[0][7];
		on_r = m[3][5] | ~pin[2] | pin[1] | m[1][7];
		ep = '{on_c, m[0][6] & ~on_c, on_r, m[1][6] & ~on_r, m[2][7],
			m[3][1] | pin[6], m[3][2], m[3][0]};
		`CHK(pwr, ep)
		`CHK(cmv, mv(m[0][5:0]))
		`CHK(rmv, mv(m[1][5:0]))
		`CHK({cmv2, rmv2}, 24'h000000)
		ex = '{m[0], m[1], {m[2][7], ~pin[4] | ~on_c, ~pin[5] | ~on_r, 5'h00},
			{2'h0, m[3][5], pin[3], 1'b0, m[3][2:0]}, 8'h00};
		for (int i = 0; i < 5; i++) begin
			rcr_host_i.rd(8'h07 + 8'(i), rd_d, ok);
			if (!ok) begin
				n_fail++;
				wrap_up();
			end
			`CHK(rd_d, ex[i])
		end
	endtask : check_all
	// ==========================================
	// Clock and main sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		pin = 7'h04;
		do_reset();
		check_all();
		$display("test reset done");
		// Codes climb one step from 37 to 63, then fall to 0
		for (int k = 0; k < 90; k++) begin
			lf = nx(lf);
			@(posedge clk);
			pin <= lf[6:0];
			m[0] = {lf[8:7], 6'((k <= 26) ? 37 + k : 89 - k)};
			m[1] = {lf[10:9], m[0][5:0]};
			m[2] = lf[23:16] & 8'h80;
			m[3] = lf[31:24] & 8'h27;
			rcr_host_i.wr(8'h07, m[0]);
			rcr_host_i.wr(8'h08, m[1]);
			rcr_host_i.wr(8'h09, lf[23:16]);
			rcr_host_i.wr(8'h0a, lf[31:24]);
			rcr_host_i.wr(8'h06, lf[15:8]); // Unmapped write must change nothing
			check_all();
		end
		$display("test sweep done");
		do_reset();
		check_all();
		$display("test second reset done");
		wrap_up();
	end
endmodule : rcr_top_tb
`default_nettype wire
